// File: core/mcpm_cfg.svh
// Register offsets, field positions and reset values of the pad multiplexer
`ifndef MCPM_CFG_SVH
`define MCPM_CFG_SVH

`define MCPM_PORT_C_SEL_OFS 12'h000
`define MCPM_PORT_D_SEL_OFS 12'h004
`define MCPM_PORT_E_SEL_OFS 12'h008
`define MCPM_PORT_G_SEL_OFS 12'h00c
`define MCPM_STRAPS_OFS     12'h010
`define MCPM_PAD_IN_OFS     12'h014
`define MCPM_SEL_RESET      16'h0000
`define MCPM_MII_SEL_RESET  16'h5555
`define MCPM_D_CE2_LSB      4
`define MCPM_D_CE1_LSB      6
`define MCPM_D_VSYNC_LSB    8
`define MCPM_D_HSYNC_LSB    10
`define MCPM_D_CCLK_LSB     12
`define MCPM_D_PCLK_LSB     14
`define MCPM_E_IORD_LSB     0
`define MCPM_G_RXD_LSB      6
`define MCPM_BA_MSB         15
`define MCPM_REGSEL_BIT     11

`endif

// File: core/mcpm_pkg.sv
// Types of the pad multiplexer
package mcpm_pkg;
  typedef logic [1:0] mcpm_sel_t;
  typedef enum logic [1:0] {
    MCPM_FN_PORT = 2'h0,
    MCPM_FN_ALT1 = 2'h1,
    MCPM_FN_ALT2 = 2'h2,
    MCPM_FN_RSVD = 2'h3
  } mcpm_fn_e;
  typedef enum logic [1:0] {
    MCPM_CYC_IDLE,
    MCPM_CYC_STATIC,
    MCPM_CYC_SDRAM,
    MCPM_CYC_CARD
  } mcpm_cyc_e;
endpackage : mcpm_pkg

// File: core/mcpm_pin_mux.sv
// Pad function multiplexer for the camera, card, memory and MII pads
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "mcpm_cfg.svh"
`default_nettype none

module mcpm_pin_mux (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                clk_en,
  // AXI4-Lite slave
  input  wire logic [11:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [11:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Memory controller side
  input  wire mcpm_pkg::mcpm_cyc_e mc_cycle,
  input  wire logic [19:0]         mc_address,
  input  wire logic [1:0]          mc_bank,
  input  wire logic [10:0]         card_address,
  input  wire logic                card_space_select_n,
  input  wire logic [15:0]         mc_wdata,
  input  wire logic                mc_data_drive,
  output logic [15:0]              mc_rdata,
  input  wire logic [2:0]          mc_chip_select_n,
  input  wire logic                mc_read_n,
  input  wire logic                mc_static_we_n,
  input  wire logic                mc_sdram_we_n,
  input  wire logic [1:0]          mc_byte_mask,
  input  wire logic                card_enable_2_n,
  input  wire logic                card_enable_1_n,
  input  wire logic                card_io_read_n,
  input  wire logic                audio0_serial_data,
  input  wire logic                camera_clock_out,
  // Memory pads
  output logic [19:0]              memory_address,
  output logic [15:0]              memory_data_o,
  output logic                     memory_data_oe_n,
  input  wire logic [15:0]         memory_data_i,
  output logic [2:0]               memory_chip_select_n,
  output logic                     memory_read_strobe_n,
  output logic                     static_write_enable_n,
  output logic                     sdram_write_enable_n,
  output logic                     sdram_clock,
  output logic                     low_byte_mask,
  output logic                     high_byte_mask,
  output logic [15:0]              mode_straps,
  // Shared pads: port C 7:0, port D 7:2, port E 0, port G 6:3
  input  wire logic [7:0]          pad_c_i,
  output logic [7:0]               pad_c_o,
  output logic [7:0]               pad_c_oe_n,
  input  wire logic [7:2]          pad_d_i,
  output logic [7:2]               pad_d_o,
  output logic [7:2]               pad_d_oe_n,
  input  wire logic                pad_e0_i,
  output logic                     pad_e0_o,
  output logic                     pad_e0_oe_n,
  input  wire logic [6:3]          pad_g_i,
  // General-purpose port controller side
  input  wire logic [7:0]          gp_c_o,
  input  wire logic [7:0]          gp_c_oe,
  input  wire logic [7:2]          gp_d_o,
  input  wire logic [7:2]          gp_d_oe,
  input  wire logic                gp_e0_o,
  input  wire logic                gp_e0_oe,
  output logic [3:0]               port_g_rx_in,
  // Function inputs towards the core
  output logic [7:0]               camera_pixel_data,
  output logic                     camera_vsync,
  output logic                     camera_hsync,
  output logic                     camera_pixel_clock_in,
  output logic [3:0]               mii_rx_data
);
  import mcpm_pkg::*;
  default clocking @(posedge aclk); endclocking // All checks sit in the one clock domain
  default disable iff (!aresetn);

  logic [15:0] port_c_sel_q;
  logic [15:0] port_d_sel_q;
  logic [15:0] port_e_sel_q;
  logic [15:0] port_g_sel_q;
  logic [15:0] mode_straps_q;
  logic        strap_taken_q;
  logic        aw_held_q;
  logic        w_held_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic        bad_wr_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic        bad_rd_q;
  logic        wr_go;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;

  // Field decode; code 3 falls back to port use
  function automatic mcpm_fn_e fn_of(input logic [15:0] reg_v, input int lsb);
    mcpm_sel_t s;
    s = reg_v[lsb +: 2];
    fn_of = (s == 2'h3) ? MCPM_FN_PORT : mcpm_fn_e'(s);
  endfunction : fn_of

  // Byte-lane merge of a 16-bit select register
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                         input logic [31:0] d, input logic [3:0] st);
    merge16 = old_v;
    if (st[0]) merge16[7:0] = d[7:0];
    if (st[1]) merge16[15:8] = d[15:8];
  endfunction : merge16

  function automatic logic known_addr(input logic [11:0] a);
    known_addr = (a == `MCPM_PORT_C_SEL_OFS) || (a == `MCPM_PORT_D_SEL_OFS) ||
                 (a == `MCPM_PORT_E_SEL_OFS) || (a == `MCPM_PORT_G_SEL_OFS) ||
                 (a == `MCPM_STRAPS_OFS) || (a == `MCPM_PAD_IN_OFS);
  endfunction : known_addr

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data taken in either order
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign wr_go   = (aw_held_q || s_axi_awvalid) && (w_held_q || s_axi_wvalid) && !bvalid_q;
  assign wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  assign wr_data = w_held_q ? wdata_q : s_axi_wdata;
  assign wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;

  // Hold whichever half arrived first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 12'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else if (clk_en) begin
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held_q <= 1'b1;
          awaddr_q  <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held_q <= 1'b1;
          wdata_q  <= s_axi_wdata;
          wstrb_q  <= s_axi_wstrb;
        end
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bad_wr_q <= 1'b0;
    end else if (clk_en) begin
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bad_wr_q <= !known_addr(wr_addr);
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bad_wr_q ? 2'h2 : 2'h0;

  // Select registers; port pins after reset, MII pads keep MII
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_c_sel_q <= `MCPM_SEL_RESET;
      port_d_sel_q <= `MCPM_SEL_RESET;
      port_e_sel_q <= `MCPM_SEL_RESET;
      port_g_sel_q <= `MCPM_MII_SEL_RESET;
    end else if (clk_en && wr_go) begin
      unique case (wr_addr)
        `MCPM_PORT_C_SEL_OFS: port_c_sel_q <= merge16(port_c_sel_q, wr_data, wr_strb);
        `MCPM_PORT_D_SEL_OFS: port_d_sel_q <= merge16(port_d_sel_q, wr_data, wr_strb);
        `MCPM_PORT_E_SEL_OFS: port_e_sel_q <= merge16(port_e_sel_q, wr_data, wr_strb);
        `MCPM_PORT_G_SEL_OFS: port_g_sel_q <= merge16(port_g_sel_q, wr_data, wr_strb);
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path, one cycle to the answer
  assign s_axi_arready = !rvalid_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      bad_rd_q <= 1'b0;
    end else if (clk_en) begin
      if (s_axi_arvalid && !rvalid_q) begin
        rvalid_q <= 1'b1;
        bad_rd_q <= !known_addr(s_axi_araddr);
        unique case (s_axi_araddr)
          `MCPM_PORT_C_SEL_OFS: rdata_q <= {16'h0000, port_c_sel_q};
          `MCPM_PORT_D_SEL_OFS: rdata_q <= {16'h0000, port_d_sel_q};
          `MCPM_PORT_E_SEL_OFS: rdata_q <= {16'h0000, port_e_sel_q};
          `MCPM_PORT_G_SEL_OFS: rdata_q <= {16'h0000, port_g_sel_q};
          `MCPM_STRAPS_OFS:     rdata_q <= {16'h0000, mode_straps_q};
          `MCPM_PAD_IN_OFS:     rdata_q <= {13'h0, pad_e0_i, pad_g_i, pad_d_i, pad_c_i};
          default:              rdata_q <= 32'h0000_0000;
        endcase
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = bad_rd_q ? 2'h2 : 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Mode straps: the first enabled edge after reset release samples the bus
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_taken_q <= 1'b0;
      mode_straps_q <= 16'h0000;
    end else if (clk_en && !strap_taken_q) begin
      strap_taken_q <= 1'b1;
      mode_straps_q <= memory_data_i;
    end
  end
  assign mode_straps = mode_straps_q;

  ////////////////////////////////////////////////////////////////////////////
  // Memory bus pads; card cycles reuse address, data and strobes
  always_comb begin
    memory_address = mc_address;
    if (mc_cycle == MCPM_CYC_SDRAM) begin
      memory_address[`MCPM_BA_MSB -: 2] = mc_bank;
    end else if (mc_cycle == MCPM_CYC_CARD) begin
      memory_address[`MCPM_REGSEL_BIT] = card_space_select_n;
      memory_address[10:0] = card_address;
    end
  end
  // Data bus held off until the straps are sampled so the strap resistors win
  assign memory_data_o        = mc_wdata;
  assign memory_data_oe_n     = !(mc_data_drive && strap_taken_q);
  assign mc_rdata             = memory_data_i;
  // Chip select 2 is only ever asserted for SDRAM cycles
  assign memory_chip_select_n = {mc_chip_select_n[2] | (mc_cycle != MCPM_CYC_SDRAM),
                                 mc_chip_select_n[1:0]};
  assign memory_read_strobe_n  = mc_read_n;
  assign static_write_enable_n = mc_static_we_n;
  assign sdram_write_enable_n  = mc_sdram_we_n | (mc_cycle != MCPM_CYC_SDRAM);
  assign sdram_clock           = aclk;
  assign low_byte_mask         = mc_byte_mask[0];
  assign high_byte_mask        = mc_byte_mask[1];

  ////////////////////////////////////////////////////////////////////////////
  // Camera pads on port C and port D
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_c_o[i]    = gp_c_o[i];
      pad_c_oe_n[i] = !gp_c_oe[i];
      camera_pixel_data[i] = 1'b0;
      if (fn_of(port_c_sel_q, 2 * i) == MCPM_FN_ALT1) begin
        pad_c_oe_n[i] = 1'b1;
        camera_pixel_data[i] = pad_c_i[i];
      end
    end
  end

  // Port D: card enables, sync inputs and camera clocks
  always_comb begin
    pad_d_o    = gp_d_o;
    pad_d_oe_n = ~gp_d_oe;
    if (fn_of(port_d_sel_q, `MCPM_D_CE2_LSB) == MCPM_FN_ALT1) begin
      pad_d_o[2]    = card_enable_2_n;
      pad_d_oe_n[2] = 1'b0;
    end
    if (fn_of(port_d_sel_q, `MCPM_D_CE1_LSB) == MCPM_FN_ALT1) begin
      pad_d_o[3]    = card_enable_1_n;
      pad_d_oe_n[3] = 1'b0;
    end
    if (fn_of(port_d_sel_q, `MCPM_D_VSYNC_LSB) == MCPM_FN_ALT1) begin
      pad_d_oe_n[4] = 1'b1;
    end
    if (fn_of(port_d_sel_q, `MCPM_D_HSYNC_LSB) == MCPM_FN_ALT1) begin
      pad_d_oe_n[5] = 1'b1;
    end
    if (fn_of(port_d_sel_q, `MCPM_D_CCLK_LSB) == MCPM_FN_ALT1) begin
      pad_d_o[6]    = camera_clock_out;
      pad_d_oe_n[6] = 1'b0;
    end
    if (fn_of(port_d_sel_q, `MCPM_D_PCLK_LSB) == MCPM_FN_ALT1) begin
      pad_d_oe_n[7] = 1'b1;
    end
  end
  // Unselected function inputs read low so idle logic sees no edges
  assign camera_vsync = (fn_of(port_d_sel_q, `MCPM_D_VSYNC_LSB) == MCPM_FN_ALT1)
                        && pad_d_i[4];
  assign camera_hsync = (fn_of(port_d_sel_q, `MCPM_D_HSYNC_LSB) == MCPM_FN_ALT1)
                        && pad_d_i[5];
  assign camera_pixel_clock_in = (fn_of(port_d_sel_q, `MCPM_D_PCLK_LSB) == MCPM_FN_ALT1)
                                 && pad_d_i[7];

  ////////////////////////////////////////////////////////////////////////////
  // Port E bit 0: card I/O read or audio serial data
  always_comb begin
    pad_e0_o    = gp_e0_o;
    pad_e0_oe_n = !gp_e0_oe;
    unique case (fn_of(port_e_sel_q, `MCPM_E_IORD_LSB))
      MCPM_FN_ALT1: begin
        pad_e0_o    = card_io_read_n;
        pad_e0_oe_n = 1'b0;
      end
      MCPM_FN_ALT2: begin
        pad_e0_o    = audio0_serial_data;
        pad_e0_oe_n = 1'b0;
      end
      default: ;
    endcase
  end

  // MII receive data pads; function 1 is MII, otherwise port G input
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (fn_of(port_g_sel_q, `MCPM_G_RXD_LSB + 2 * i) == MCPM_FN_ALT1) begin
        mii_rx_data[i]  = pad_g_i[i + 3];
        port_g_rx_in[i] = 1'b0;
      end else begin
        mii_rx_data[i]  = 1'b0;
        port_g_rx_in[i] = pad_g_i[i + 3];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_vsync_gate: assert property ((fn_of(port_d_sel_q, `MCPM_D_VSYNC_LSB) != MCPM_FN_ALT1)
    |-> !camera_vsync) else $error("vsync passes while not selected");
  a_cam_data: assert property ((port_c_sel_q == 16'h5555) |->
    (camera_pixel_data == pad_c_i && pad_c_oe_n == 8'hff)) else $error("camera data not routed");
  a_ce2_drive: assert property ((port_d_sel_q[5:4] == 2'h1) |->
    (!pad_d_oe_n[2] && pad_d_o[2] == card_enable_2_n)) else $error("card enable 2 not driven");
  a_ce1_drive: assert property ((port_d_sel_q[7:6] == 2'h1) |->
    (!pad_d_oe_n[3] && pad_d_o[3] == card_enable_1_n)) else $error("card enable 1 not driven");
  a_code3_port: assert property ((port_e_sel_q[1:0] == 2'h3) |->
    (pad_e0_o == gp_e0_o)) else $error("code 3 not port use");
  a_iord_audio: assert property ((port_e_sel_q[1:0] == 2'h2) |->
    (pad_e0_o == audio0_serial_data)) else $error("audio data not routed");
  a_card_addr: assert property ((mc_cycle == MCPM_CYC_CARD) |-> (memory_address[10:0] ==
    card_address && memory_address[11] == card_space_select_n)) else $error("card address lost");
  a_bank_addr: assert property ((mc_cycle == MCPM_CYC_SDRAM) |->
    (memory_address[15:14] == mc_bank)) else $error("bank address missing");
  a_cs2_sdram: assert property (!memory_chip_select_n[2] |-> (mc_cycle == MCPM_CYC_SDRAM))
    else $error("chip select 2 outside SDRAM");
  a_strap_hold: assert property (strap_taken_q && $past(strap_taken_q) |->
    $stable(mode_straps)) else $error("straps changed after capture");
  a_write_resp: assert property (clk_en && wr_go |=> s_axi_bvalid)
    else $error("write response late");
  c_card_cycle: cover property (mc_cycle == MCPM_CYC_CARD);
  c_cam_select: cover property (camera_pixel_clock_in);
  c_audio_sel: cover property (port_e_sel_q[1:0] == 2'h2);
endmodule : mcpm_pin_mux

`default_nettype wire

// File: verification/mcpm_far_side.sv
// Far-side model of the memory data bus: strap resistors, card and pull-downs
`timescale 1ns/1ps
`default_nettype none

module mcpm_far_side #(
  parameter logic [15:0] STRAPS    = 16'h0000,
  parameter logic [15:0] CARD_DATA = 16'h0000
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        card_read,
  input  wire logic [15:0] memory_data_o,
  input  wire logic        memory_data_oe_n,
  output logic [15:0]      memory_data_i
);
  logic strap_hold_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Strap resistors stay visible until the first edge after reset release
  always_ff @(posedge aclk) begin
    strap_hold_q <= !aresetn;
  end

  // Straps while held, then own driver, then the card; otherwise the pull-downs win, not the old value
  always_comb begin
    if (strap_hold_q) memory_data_i = STRAPS;
    else if (!memory_data_oe_n) memory_data_i = memory_data_o;
    else if (card_read) memory_data_i = CARD_DATA;
    else memory_data_i = 16'h0000;
  end
endmodule : mcpm_far_side
`default_nettype wire

// File: verification/mcpm_pin_mux_bench.sv
// Self-checking bench of the pad multiplexer
`timescale 1ns/1ps
`include "mcpm_cfg.svh"
`default_nettype none

module mcpm_pin_mux_bench;
  import mcpm_pkg::*;
  logic aclk, aresetn, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, rd;
  logic [3:0]  s_axi_wstrb, port_g_rx_in, mii_rx_data;
  logic [1:0]  s_axi_bresp, s_axi_rresp, mc_bank, mc_byte_mask, resp;
  mcpm_cyc_e   mc_cycle;
  logic [19:0] mc_address, memory_address;
  logic [10:0] card_address;
  logic [15:0] mc_wdata, mc_rdata, memory_data_o, memory_data_i, mode_straps;
  logic [15:0] selc, seld, sele, selg;
  logic card_space_select_n, mc_data_drive, mc_read_n, mc_static_we_n, mc_sdram_we_n;
  logic card_enable_2_n, card_enable_1_n, card_io_read_n, audio0_serial_data, camera_clock_out;
  logic memory_data_oe_n, memory_read_strobe_n, static_write_enable_n, sdram_write_enable_n;
  logic sdram_clock, low_byte_mask, high_byte_mask, pad_e0_i, pad_e0_o, pad_e0_oe_n;
  logic gp_e0_o, gp_e0_oe, camera_vsync, camera_hsync, camera_pixel_clock_in;
  logic [2:0]  mc_chip_select_n, memory_chip_select_n;
  logic [7:0]  pad_c_i, pad_c_o, pad_c_oe_n, gp_c_o, gp_c_oe, camera_pixel_data;
  logic [7:2]  pad_d_i, pad_d_o, pad_d_oe_n, gp_d_o, gp_d_oe;
  logic [6:3]  pad_g_i;
  int          mismatches, total_checks;
  localparam logic [15:0] STRAPS = 16'ha5c3;
  localparam logic [15:0] CARD_DATA = 16'h3c5a;

  mcpm_pin_mux DUT (.*);
  mcpm_far_side #(.STRAPS(STRAPS), .CARD_DATA(CARD_DATA)) far (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .card_read        (mc_cycle == MCPM_CYC_CARD && !memory_read_strobe_n),
    .memory_data_o    (memory_data_o),
    .memory_data_oe_n (memory_data_oe_n),
    .memory_data_i    (memory_data_i)
  );

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs

  // Field decode; code 3 falls back to port use
  function automatic logic [1:0] fn(input logic [15:0] sel, input int i);
    return (sel[2*i +: 2] == 2'h3) ? 2'h0 : sel[2*i +: 2];
  endfunction : fn

  // Expected {oe_n, driven value}; an undriven pad shows 0 in the value bit
  function automatic logic [1:0] pad(input logic [1:0] c, input logic out, input logic f1,
                                     input logic f2, input logic go, input logic ge);
    if (c == 2'h1) return out ? {1'b0, f1} : 2'b10;
    if (c == 2'h2) return {1'b0, f2};
    return {~ge, go & ge};
  endfunction : pad

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // Both write halves offered together; each dropped once taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    logic aw, w, b;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!b);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a);
    logic ar, r;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end while (!r);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd

  // Every function-side and shared-pad input gets fresh random bits; memory_data_i comes from the far-side model
  task automatic rand_inputs();
    logic [127:0] r;
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      r = {r[95:0], seed};
    end
    mc_cycle <= mcpm_cyc_e'(r[1:0]);
    {mc_address, card_address, mc_wdata, mc_bank, mc_byte_mask, mc_chip_select_n} <= r[55:2];
    {card_space_select_n, mc_data_drive, mc_read_n, mc_static_we_n, mc_sdram_we_n, card_enable_2_n,
     card_enable_1_n, card_io_read_n, audio0_serial_data, camera_clock_out} <= r[65:56];
    {pad_c_i, pad_d_i, pad_e0_i, pad_g_i, gp_c_o, gp_c_oe, gp_d_o, gp_d_oe, gp_e0_o,
     gp_e0_oe} <= r[114:66];
  endtask : rand_inputs

  // Called at a falling edge, where the combinational pad paths have settled
  task automatic check_pads();
    logic sd, cd;
    logic [7:2] srcd;
    sd = (mc_cycle == MCPM_CYC_SDRAM);
    cd = (mc_cycle == MCPM_CYC_CARD);
    srcd = {1'b0, camera_clock_out, 2'b00, card_enable_1_n, card_enable_2_n};
    for (int i = 0; i < 8; i++) begin
      check(camera_pixel_data[i], (fn(selc, i) == 2'h1) ? pad_c_i[i] : 1'b0);
      if (fn(selc, i) != 2'h2) check({pad_c_oe_n[i], pad_c_o[i] & ~pad_c_oe_n[i]},
          pad(fn(selc, i), 1'b0, 1'b0, 1'b0, gp_c_o[i], gp_c_oe[i]));
    end
    for (int k = 2; k < 8; k++) begin
      if (fn(seld, k) != 2'h2) check({pad_d_oe_n[k], pad_d_o[k] & ~pad_d_oe_n[k]},
          pad(fn(seld, k), k inside {2, 3, 6}, srcd[k], 1'b0, gp_d_o[k], gp_d_oe[k]));
    end
    check(camera_vsync, (fn(seld, 4) == 2'h1) ? pad_d_i[4] : 1'b0);
    check(camera_hsync, (fn(seld, 5) == 2'h1) ? pad_d_i[5] : 1'b0);
    check(camera_pixel_clock_in, (fn(seld, 7) == 2'h1) ? pad_d_i[7] : 1'b0);
    check({pad_e0_oe_n, pad_e0_o & ~pad_e0_oe_n}, pad(fn(sele, 0), 1'b1, card_io_read_n,
          audio0_serial_data, gp_e0_o, gp_e0_oe));
    for (int i = 3; i < 7; i++) begin
      if (fn(selg, i) != 2'h2) check({mii_rx_data[i-3], port_g_rx_in[i-3]},
          (fn(selg, i) == 2'h1) ? {pad_g_i[i], 1'b0} : {1'b0, pad_g_i[i]});
    end
    check(memory_address[15:14], sd ? mc_bank : mc_address[15:14]);
    check(memory_address[11], cd ? card_space_select_n : mc_address[11]);
    check(memory_address[10:0], cd ? card_address : mc_address[10:0]);
    check(memory_chip_select_n, {sd ? mc_chip_select_n[2] : 1'b1, mc_chip_select_n[1:0]});
    check(memory_read_strobe_n, mc_read_n);
    check({static_write_enable_n, sdram_write_enable_n},
          {mc_static_we_n, sd ? mc_sdram_we_n : 1'b1});
    check({high_byte_mask, low_byte_mask}, mc_byte_mask);
    check({memory_data_oe_n, memory_data_o}, {~mc_data_drive, mc_wdata});
    if (cd && !mc_read_n && !mc_data_drive) check(mc_rdata, CARD_DATA);
    #1 check(sdram_clock, 1'b0);
  endtask : check_pads

  task automatic settle();
    repeat (4) begin
      rand_inputs();
      @(negedge aclk);
      check_pads();
      @(posedge aclk);
    end
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running 250 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // Cuts a hang short
  initial begin
    #100000;
    mismatches++;
    summarize();
  end

  // Main sequence: reset values, unmapped access, then random selections
  initial begin
    seed = 32'd73;
    mismatches = 0;
    total_checks = 0;
    aresetn = 1'b0;
    clk_en = 1'b1;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    rand_inputs();
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 5; i++) begin
      axi_rd(12'(4 * i));
      check(rd, (i == 3) ? 32'h5555 : (i == 4) ? {16'h0000, STRAPS} : 32'h0);
    end
    check(mode_straps, STRAPS);
    axi_rd(12'h100);
    check(resp, 2'h2);
    check(rd, 32'h0);
    axi_wr(12'h100, 32'hffff);
    check(resp, 2'h2);
    {selc, seld, sele, selg} = {48'h0, 16'h5555};
    settle();
    for (int n = 0; n < 40; n++) begin
      seed = xs(seed);
      {selc, seld} = (n < 4) ? {16{2'(n)}} : seed;
      seed = xs(seed);
      {sele, selg} = (n < 4) ? {16{2'(n)}} : seed;
      axi_wr(`MCPM_PORT_C_SEL_OFS, {16'h0000, selc});
      check(resp, 2'h0);
      axi_wr(`MCPM_PORT_D_SEL_OFS, {16'h0000, seld});
      axi_wr(`MCPM_PORT_E_SEL_OFS, {16'h0000, sele});
      axi_wr(`MCPM_PORT_G_SEL_OFS, {16'h0000, selg});
      axi_rd(`MCPM_PORT_D_SEL_OFS);
      check(rd, {16'h0000, seld});
      settle();
    end
    // Upper lane alone must leave the lower byte of the select untouched
    s_axi_wstrb <= 4'h2;
    axi_wr(`MCPM_PORT_C_SEL_OFS, 32'h0000_a5a5);
    axi_rd(`MCPM_PORT_C_SEL_OFS);
    check(rd, {16'h0000, 8'ha5, selc[7:0]});
    axi_rd(`MCPM_PAD_IN_OFS);
    check(rd, {13'h0, pad_e0_i, pad_g_i, pad_d_i, pad_c_i});
    summarize();
  end
endmodule : mcpm_pin_mux_bench
`default_nettype wire
